/* File: core/bsme_core.sv */
// Execution unit for multiply, compare, skip and conditional branch instructions
// Function
// - Signed-by-unsigned multiply writes product pair, updates Z and C, two cycles.
// - Fractional multiplies shift product left one, write pair, Z and C, two cycles.
// - Compare-skip-equal skips next instruction when registers match; flags untouched.
// - Compare-immediate subtracts constant, sets Z N V S C H, one cycle, no store.
// - Skip when chosen working register bit is zero; flags untouched.
// - Skip when chosen working register bit is one; flags untouched.
// - Skip when chosen I/O register bit is zero; flags untouched.
// - Skip when chosen I/O register bit is one; flags untouched.
// - Branch to pc plus offset plus one when selected status bit is one.
// - Branch to pc plus offset plus one when selected status bit is zero.
// - Equal, not-equal, carry, minus and plus branches test single flags.
// - Same-or-higher branches on carry clear, lower on carry set.
// - Signed branches test N xor V: zero for ge, one for lt.
// - Half-carry branches test H set or clear, no flag change.
// - Transfer-bit branches test T set or clear, no flag change.
// - Multiplies exist only in the large variant; otherwise refused.
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module bsme_core #(
	parameter int PC_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cmd_valid_i,
	input wire bsme_pkg::bsme_cmd_t cmd_i,
	output logic busy_o,
	output logic done_o,
	output logic [PC_W-1:0] pc_o,
	output logic [7:0] status_register_o,
	output logic [15:0] product_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic is_mul(input bsme_pkg::bsme_op_t op);
		is_mul = (op == bsme_pkg::op_mult_signed_by_unsigned) || (op == bsme_pkg::op_frac_mult_unsigned) ||
			(op == bsme_pkg::op_frac_mult_signed) || (op == bsme_pkg::op_frac_mult_signed_unsigned);
	endfunction : is_mul

	function automatic logic is_skip(input bsme_pkg::bsme_op_t op);
		is_skip = (op == bsme_pkg::op_compare_skip_equal) || (op == bsme_pkg::op_skip_reg_bit_clear) ||
			(op == bsme_pkg::op_skip_reg_bit_set) || (op == bsme_pkg::op_skip_io_bit_clear) ||
			(op == bsme_pkg::op_skip_io_bit_set);
	endfunction : is_skip

	function automatic logic is_branch(input bsme_pkg::bsme_op_t op);
		is_branch = (op >= bsme_pkg::op_branch_flag_set) && (op <= bsme_pkg::op_branch_tbit_clear);
	endfunction : is_branch

	// True when a skip skips or a branch is taken
	function automatic logic take_cond(input bsme_pkg::bsme_cmd_t c, input logic [7:0] s);
		case (c.op)
			bsme_pkg::op_compare_skip_equal: take_cond = (c.rd_val == c.rr_val);
			bsme_pkg::op_skip_reg_bit_clear: take_cond = ~c.rr_val[c.bit_sel];
			bsme_pkg::op_skip_reg_bit_set: take_cond = c.rr_val[c.bit_sel];
			bsme_pkg::op_skip_io_bit_clear: take_cond = ~c.io_val[c.bit_sel];
			bsme_pkg::op_skip_io_bit_set: take_cond = c.io_val[c.bit_sel];
			bsme_pkg::op_branch_flag_set: take_cond = s[c.bit_sel];
			bsme_pkg::op_branch_flag_clear: take_cond = ~s[c.bit_sel];
			bsme_pkg::op_branch_equal: take_cond = s[bsme_pkg::FLAG_Z];
			bsme_pkg::op_branch_not_equal: take_cond = ~s[bsme_pkg::FLAG_Z];
			bsme_pkg::op_branch_carry_set: take_cond = s[bsme_pkg::FLAG_C];
			bsme_pkg::op_branch_carry_clear: take_cond = ~s[bsme_pkg::FLAG_C];
			bsme_pkg::op_branch_minus: take_cond = s[bsme_pkg::FLAG_N];
			bsme_pkg::op_branch_plus: take_cond = ~s[bsme_pkg::FLAG_N];
			bsme_pkg::op_branch_same_or_higher: take_cond = ~s[bsme_pkg::FLAG_C];
			bsme_pkg::op_branch_lower: take_cond = s[bsme_pkg::FLAG_C];
			bsme_pkg::op_branch_ge_signed: take_cond = ~(s[bsme_pkg::FLAG_N] ^ s[bsme_pkg::FLAG_V]);
			bsme_pkg::op_branch_lt_signed: take_cond = s[bsme_pkg::FLAG_N] ^ s[bsme_pkg::FLAG_V];
			bsme_pkg::op_branch_half_carry_set: take_cond = s[bsme_pkg::FLAG_H];
			bsme_pkg::op_branch_half_carry_clear: take_cond = ~s[bsme_pkg::FLAG_H];
			bsme_pkg::op_branch_tbit_set: take_cond = s[bsme_pkg::FLAG_T];
			bsme_pkg::op_branch_tbit_clear: take_cond = ~s[bsme_pkg::FLAG_T];
			default: take_cond = 1'b0;
		endcase
	endfunction : take_cond

	// ----------------------------------------
	// State
	// ----------------------------------------
	bsme_pkg::bsme_state_t state_q;
	logic [1:0] stall_q;
	logic busy_q;
	logic done_q;
	logic [PC_W-1:0] pc_q;
	logic [7:0] status_register_q;
	logic [15:0] product_q;
	logic [7:0] ctrl_q;
	logic illegal_q;
	logic ack_q;
	logic [31:0] rdat_q;

	logic accept;
	logic cond;
	logic mul_ok;
	logic mul_wr;
	logic [PC_W-1:0] pc_d;
	logic [1:0] stall_d;
	logic [PC_W-1:0] ofs_ext;
	logic [15:0] mul_prod;
	logic mul_carry;
	logic mul_zero;
	logic [7:0] diff;
	logic wb_hit;
	logic wb_wr;

	assign accept = ce_i && cmd_valid_i && !busy_q;
	assign cond = take_cond(cmd_i, status_register_q);
	assign mul_ok = ctrl_q[bsme_pkg::CTRL_LARGE_BIT];
	assign mul_wr = (state_q == bsme_pkg::st_mul);
	assign ofs_ext = {{(PC_W-bsme_pkg::OFS_W){cmd_i.offset[bsme_pkg::OFS_W-1]}}, cmd_i.offset};
	assign diff = cmd_i.rd_val - cmd_i.rr_val;
	assign wb_hit = wb_cyc_i && wb_stb_i && !ack_q;
	assign wb_wr = wb_hit && wb_we_i && wb_sel_i[0];

	// ----------------------------------------
	// Next pc and stall length
	// ----------------------------------------
	always_comb begin
		pc_d = pc_q + 1'b1;
		stall_d = bsme_pkg::STALL_NONE;
		if (is_branch(cmd_i.op) && cond) begin
			// taken branch costs one more cycle
			pc_d = pc_q + ofs_ext + 1'b1;
			stall_d = bsme_pkg::STALL_BRANCH;
		end else if (is_skip(cmd_i.op) && cond) begin
			if (cmd_i.next_two_word) begin
				pc_d = pc_q + PC_W'(3);
				stall_d = bsme_pkg::STALL_SKIP_TWO;
			end else begin
				pc_d = pc_q + PC_W'(2);
				stall_d = bsme_pkg::STALL_SKIP_ONE;
			end
		end
	end

	// ----------------------------------------
	// Multiplier
	// ----------------------------------------
	bsme_mul #(
		.W(bsme_pkg::DATA_W)
	) u_mul (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.start_i(accept && is_mul(cmd_i.op) && mul_ok),
		.a_i(cmd_i.rd_val),
		.b_i(cmd_i.rr_val),
		.a_signed_i(cmd_i.op != bsme_pkg::op_frac_mult_unsigned),
		.b_signed_i(cmd_i.op == bsme_pkg::op_frac_mult_signed),
		.frac_i(cmd_i.op != bsme_pkg::op_mult_signed_by_unsigned),
		.prod_o(mul_prod),
		.carry_o(mul_carry),
		.zero_o(mul_zero)
	);

	// ----------------------------------------
	// Sequencer and program counter
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= bsme_pkg::st_idle;
			stall_q <= bsme_pkg::STALL_NONE;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			pc_q <= '0;
		end else if (ce_i) begin
			done_q <= 1'b0;
			case (state_q)
				bsme_pkg::st_idle: begin
					if (accept) begin
						pc_q <= pc_d;
						if (is_mul(cmd_i.op) && mul_ok) begin
							state_q <= bsme_pkg::st_mul;
							busy_q <= 1'b1;
						end else if (stall_d != bsme_pkg::STALL_NONE) begin
							state_q <= bsme_pkg::st_stall;
							stall_q <= stall_d;
							busy_q <= 1'b1;
						end else begin
							done_q <= 1'b1;
						end
					end else if (wb_wr && wb_adr_i == bsme_pkg::ADR_PC) begin
						pc_q <= wb_dat_i[PC_W-1:0];
					end
				end
				bsme_pkg::st_mul: begin
					state_q <= bsme_pkg::st_idle;
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
				bsme_pkg::st_stall: begin
					if (stall_q == 2'h1) begin
						state_q <= bsme_pkg::st_idle;
						busy_q <= 1'b0;
						done_q <= 1'b1;
					end
					stall_q <= stall_q - 1'b1;
				end
				default: begin
					state_q <= bsme_pkg::st_idle;
					busy_q <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Status flags and product pair
	// ----------------------------------------
	// Instruction updates win over a software write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_register_q <= bsme_pkg::STATUS_REGISTER_RST;
		end else if (ce_i) begin
			if (accept && cmd_i.op == bsme_pkg::op_compare_immediate) begin
				status_register_q[bsme_pkg::FLAG_Z] <= (diff == 8'h00);
				status_register_q[bsme_pkg::FLAG_N] <= diff[7];
				status_register_q[bsme_pkg::FLAG_V] <= (cmd_i.rd_val[7] & ~cmd_i.rr_val[7] & ~diff[7]) |
					(~cmd_i.rd_val[7] & cmd_i.rr_val[7] & diff[7]);
				status_register_q[bsme_pkg::FLAG_S] <= diff[7] ^ ((cmd_i.rd_val[7] & ~cmd_i.rr_val[7] & ~diff[7]) |
					(~cmd_i.rd_val[7] & cmd_i.rr_val[7] & diff[7]));
				status_register_q[bsme_pkg::FLAG_C] <= (~cmd_i.rd_val[7] & cmd_i.rr_val[7]) | (cmd_i.rr_val[7] & diff[7]) |
					(diff[7] & ~cmd_i.rd_val[7]);
				status_register_q[bsme_pkg::FLAG_H] <= (~cmd_i.rd_val[3] & cmd_i.rr_val[3]) | (cmd_i.rr_val[3] & diff[3]) |
					(diff[3] & ~cmd_i.rd_val[3]);
			end else if (mul_wr) begin
				status_register_q[bsme_pkg::FLAG_Z] <= mul_zero;
				status_register_q[bsme_pkg::FLAG_C] <= mul_carry;
			end else if (wb_wr && wb_adr_i == bsme_pkg::ADR_STATUS) begin
				status_register_q <= wb_dat_i[7:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			product_q <= bsme_pkg::PRODUCT_RST;
		end else if (ce_i && mul_wr) begin
			product_q <= mul_prod;
		end
	end

	// ----------------------------------------
	// Control and refused-instruction event
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= bsme_pkg::CTRL_RST;
			illegal_q <= 1'b0;
		end else if (ce_i) begin
			if (wb_wr && wb_adr_i == bsme_pkg::ADR_CTRL) begin
				ctrl_q <= wb_dat_i[7:0];
			end
			// refused multiply is flagged; set beats clear
			if (accept && is_mul(cmd_i.op) && !mul_ok) begin
				illegal_q <= 1'b1;
			end else if (wb_wr && wb_adr_i == bsme_pkg::ADR_EVENT && wb_dat_i[bsme_pkg::EVT_ILLEGAL_BIT]) begin
				illegal_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	// Unmapped addresses ack with zero data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_q <= wb_hit;
			rdat_q <= 32'h0000_0000;
			if (wb_hit && !wb_we_i) begin
				case (wb_adr_i)
					bsme_pkg::ADR_CTRL: rdat_q <= {24'h00_0000, ctrl_q};
					bsme_pkg::ADR_STATUS: rdat_q <= {24'h00_0000, status_register_q};
					bsme_pkg::ADR_PC: rdat_q <= 32'(pc_q);
					bsme_pkg::ADR_EVENT: rdat_q <= {31'h0000_0000, illegal_q};
					bsme_pkg::ADR_PRODUCT: rdat_q <= {16'h0000, product_q};
					default: rdat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign busy_o = busy_q;
	assign done_o = done_q;
	assign pc_o = pc_q;
	assign status_register_o = status_register_q;
	assign product_o = product_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	mul_two_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		(accept && cmd_i.op == bsme_pkg::op_mult_signed_by_unsigned && mul_ok) |=> !done_q ##1 done_q)
		else $error("multiply did not finish in two cycles");

	frac_shift_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		(accept && is_mul(cmd_i.op) && cmd_i.op != bsme_pkg::op_mult_signed_by_unsigned && mul_ok)
		|=> ##1 (product_o[0] == 1'b0 && status_register_o[bsme_pkg::FLAG_Z] == (product_o == 16'h0000)))
		else $error("fractional product not shifted");

	skip_equal_pc_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		(accept && cmd_i.op == bsme_pkg::op_compare_skip_equal && cmd_i.rd_val == cmd_i.rr_val
		&& !cmd_i.next_two_word) |=> pc_q == $past(pc_q) + PC_W'(2))
		else $error("equal skip pc wrong");

	cmp_imm_flags_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		(accept && cmd_i.op == bsme_pkg::op_compare_immediate) |=>
		(status_register_q[bsme_pkg::FLAG_Z] == ($past(cmd_i.rd_val) == $past(cmd_i.rr_val))) &&
		(status_register_q[bsme_pkg::FLAG_C] == ($past(cmd_i.rd_val) < $past(cmd_i.rr_val))) && done_q)
		else $error("compare immediate flags wrong");

	skip_two_word_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		(accept && is_skip(cmd_i.op) && cond && cmd_i.next_two_word) |=>
		busy_q [*2] ##1 (done_q && !busy_q && pc_q == $past(pc_q, 3) + PC_W'(3)))
		else $error("two word skip timing wrong");

	skip_keeps_flags_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		(accept && is_skip(cmd_i.op) && !wb_wr) |=> $stable(status_register_q))
		else $error("skip changed flags");

	branch_taken_pc_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		(accept && is_branch(cmd_i.op) && cond) |=>
		(pc_q == $past(pc_q) + $past(ofs_ext) + 1'b1) && busy_q ##1 done_q)
		else $error("taken branch pc or timing wrong");

	branch_not_taken_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		(accept && is_branch(cmd_i.op) && !cond) |=> (pc_q == $past(pc_q) + 1'b1) && done_q && !busy_q)
		else $error("untaken branch timing wrong");

	signed_branch_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		(accept && cmd_i.op == bsme_pkg::op_branch_lt_signed &&
		(status_register_q[bsme_pkg::FLAG_N] != status_register_q[bsme_pkg::FLAG_V])) |=> busy_q)
		else $error("signed less-than not taken");

	refused_mul_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		(accept && is_mul(cmd_i.op) && !mul_ok) |=> illegal_q && done_q && $stable(product_q))
		else $error("refused multiply not flagged");
endmodule : bsme_core
`default_nettype wire

/* File: core/bsme_pkg.sv */
// Shared constants, types and register map for the branch/skip/multiply execution unit
package bsme_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int OFS_W = 7;
	localparam int BIT_SEL_W = 3;

	// ----------------------------------------
	// Status register flag positions
	// ----------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [4:0] ADR_CTRL = 5'h00;
	localparam logic [4:0] ADR_STATUS = 5'h04;
	localparam logic [4:0] ADR_PC = 5'h08;
	localparam logic [4:0] ADR_EVENT = 5'h0c;
	localparam logic [4:0] ADR_PRODUCT = 5'h10;

	localparam int CTRL_LARGE_BIT = 0;
	localparam int EVT_ILLEGAL_BIT = 0;
	localparam logic [7:0] CTRL_RST = 8'h01;
	localparam logic [7:0] STATUS_REGISTER_RST = 8'h00;
	localparam logic [15:0] PRODUCT_RST = 16'h0000;

	// ----------------------------------------
	// Extra cycles after the issue cycle
	// ----------------------------------------
	localparam logic [1:0] STALL_NONE = 2'h0;
	localparam logic [1:0] STALL_BRANCH = 2'h1;
	localparam logic [1:0] STALL_SKIP_ONE = 2'h1;
	localparam logic [1:0] STALL_SKIP_TWO = 2'h2;

	// ----------------------------------------
	// Instruction codes
	// ----------------------------------------
	typedef enum logic [4:0] {
		op_nop = 5'h00,
		op_mult_signed_by_unsigned = 5'h01,
		op_frac_mult_unsigned = 5'h02,
		op_frac_mult_signed = 5'h03,
		op_frac_mult_signed_unsigned = 5'h04,
		op_compare_skip_equal = 5'h05,
		op_compare_immediate = 5'h06,
		op_skip_reg_bit_clear = 5'h07,
		op_skip_reg_bit_set = 5'h08,
		op_skip_io_bit_clear = 5'h09,
		op_skip_io_bit_set = 5'h0a,
		op_branch_flag_set = 5'h0b,
		op_branch_flag_clear = 5'h0c,
		op_branch_equal = 5'h0d,
		op_branch_not_equal = 5'h0e,
		op_branch_carry_set = 5'h0f,
		op_branch_carry_clear = 5'h10,
		op_branch_same_or_higher = 5'h11,
		op_branch_lower = 5'h12,
		op_branch_minus = 5'h13,
		op_branch_plus = 5'h14,
		op_branch_ge_signed = 5'h15,
		op_branch_lt_signed = 5'h16,
		op_branch_half_carry_set = 5'h17,
		op_branch_half_carry_clear = 5'h18,
		op_branch_tbit_set = 5'h19,
		op_branch_tbit_clear = 5'h1a
	} bsme_op_t;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_mul = 3'b010,
		st_stall = 3'b100
	} bsme_state_t;

	// rr_val doubles as the immediate for compare-with-immediate
	typedef struct packed {
		bsme_op_t op;
		logic [7:0] rd_val;
		logic [7:0] rr_val;
		logic [2:0] bit_sel;
		logic [7:0] io_val;
		logic [6:0] offset;
		logic next_two_word;
	} bsme_cmd_t;

endpackage : bsme_pkg

/* File: core/bsme_mul.sv */
// Registered 8x8 multiplier with signed, mixed and fractional modes
`timescale 1ns/10ps
`default_nettype none
module bsme_mul #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire logic [W-1:0] a_i,
	input wire logic [W-1:0] b_i,
	input wire logic a_signed_i,
	input wire logic b_signed_i,
	input wire logic frac_i,
	output logic [2*W-1:0] prod_o,
	output logic carry_o,
	output logic zero_o
);
	logic signed [W:0] a_ext;
	logic signed [W:0] b_ext;
	logic signed [2*W+1:0] full;
	logic [2*W-1:0] raw;
	logic [2*W-1:0] res;

	assign a_ext = $signed({a_signed_i & a_i[W-1], a_i});
	assign b_ext = $signed({b_signed_i & b_i[W-1], b_i});
	assign full = a_ext * b_ext;
	assign raw = full[2*W-1:0];
	// Fractional result drops the duplicated sign bit
	assign res = frac_i ? {raw[2*W-2:0], 1'b0} : raw;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prod_o <= '0;
			carry_o <= 1'b0;
			zero_o <= 1'b0;
		end else if (ce_i && start_i) begin
			prod_o <= res;
			// Carry is taken from the unshifted product
			carry_o <= raw[2*W-1];
			zero_o <= (res == '0);
		end
	end
endmodule : bsme_mul
`default_nettype wire

/* File: sim/branch_skip_multiply_exec_test.sv */
// Self-checking bench for the branch, skip and multiply execution unit
`timescale 1ns/10ps
`default_nettype none
module branch_skip_multiply_exec_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	bsme_pkg::bsme_cmd_t cmd_i = '0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [4:0] wb_adr_i = 5'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic busy_o;
	logic done_o;
	logic [15:0] pc_o;
	logic [7:0] status_register_o;
	logic [15:0] product_o;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	int bad_count = 0;
	int n_compared = 0;
	integer seed = 32'h4358_b008;
	logic [31:0] rd_q;
	logic [7:0] exp_status_register;
	logic [15:0] exp_pc;
	logic [15:0] exp_prod = 16'h0000;
	int exp_cyc;
	bsme_pkg::bsme_cmd_t c;
	logic [7:0] s;
	logic [15:0] p;

	bsme_core #(.PC_W(16)) u_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.cmd_valid_i(cmd_valid_i),
		.cmd_i(cmd_i),
		.busy_o(busy_o),
		.done_o(done_o),
		.pc_o(pc_o),
		.status_register_o(status_register_o),
		.product_o(product_o),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o)
	);

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		if (bad_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	task automatic hung();
		bad_count++;
		$display("ERROR %0t: wait bound used up", $time);
		wrap_up();
	endtask : hung

	// Entered just after a rising edge; holds the request until ack is sampled
	task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hf;
		wb_dat_i <= dat;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) hung();
		rd_q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic issue(input bsme_pkg::bsme_cmd_t cmd);
		int n;
		n = 0;
		cmd_valid_i <= 1'b1;
		cmd_i <= cmd;
		@(posedge clk_i);
		cmd_valid_i <= 1'b0;
		do begin
			@(posedge clk_i);
			n++;
		end while (done_o !== 1'b1 && n < 8);
		if (done_o !== 1'b1) hung();
		check(32'(n), 32'(exp_cyc));
		check(32'(busy_o), 32'h0000_0000);
		check(32'(status_register_o), 32'(exp_status_register));
		check(32'(product_o), 32'(exp_prod));
	endtask : issue

	// ----------------------------------------
	// Expected results
	// ----------------------------------------
	function automatic void model(input bsme_pkg::bsme_cmd_t x, input logic [7:0] st, input logic [15:0] pcv);
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] raw;
		logic [7:0] d;
		logic [7:0] k;
		logic cond;
		a = {8'h00, x.rd_val};
		b = {8'h00, x.rr_val};
		k = x.rr_val;
		cond = 1'b0;
		exp_status_register = st;
		exp_pc = pcv + 16'h0001;
		exp_cyc = 1;
		if (x.op <= bsme_pkg::op_frac_mult_signed_unsigned) begin
			if (x.op != bsme_pkg::op_frac_mult_unsigned) a[15:8] = {8{x.rd_val[7]}};
			if (x.op == bsme_pkg::op_frac_mult_signed) b[15:8] = {8{x.rr_val[7]}};
			raw = a * b;
			exp_prod = (x.op == bsme_pkg::op_mult_signed_by_unsigned) ? raw : {raw[14:0], 1'b0};
			exp_status_register[0] = raw[15];
			exp_status_register[1] = (exp_prod == 16'h0000);
			exp_cyc = 2;
		end else if (x.op == bsme_pkg::op_compare_immediate) begin
			d = x.rd_val - k;
			exp_status_register[0] = (x.rd_val < k);
			exp_status_register[1] = (d == 8'h00);
			exp_status_register[2] = d[7];
			exp_status_register[3] = (x.rd_val[7] & ~k[7] & ~d[7]) | (~x.rd_val[7] & k[7] & d[7]);
			exp_status_register[4] = exp_status_register[2] ^ exp_status_register[3];
			exp_status_register[5] = (~x.rd_val[3] & k[3]) | (k[3] & d[3]) | (d[3] & ~x.rd_val[3]);
		end else if (x.op <= bsme_pkg::op_skip_io_bit_set) begin
			case (x.op)
				bsme_pkg::op_compare_skip_equal: cond = (x.rd_val == x.rr_val);
				bsme_pkg::op_skip_reg_bit_clear: cond = !x.rr_val[x.bit_sel];
				bsme_pkg::op_skip_reg_bit_set: cond = x.rr_val[x.bit_sel];
				bsme_pkg::op_skip_io_bit_clear: cond = !x.io_val[x.bit_sel];
				default: cond = x.io_val[x.bit_sel];
			endcase
			if (cond) begin
				exp_pc = pcv + (x.next_two_word ? 16'h0003 : 16'h0002);
				exp_cyc = x.next_two_word ? 3 : 2;
			end
		end else begin
			case (x.op)
				bsme_pkg::op_branch_flag_set: cond = st[x.bit_sel];
				bsme_pkg::op_branch_flag_clear: cond = !st[x.bit_sel];
				bsme_pkg::op_branch_equal: cond = st[1];
				bsme_pkg::op_branch_not_equal: cond = !st[1];
				bsme_pkg::op_branch_carry_set, bsme_pkg::op_branch_lower: cond = st[0];
				bsme_pkg::op_branch_carry_clear, bsme_pkg::op_branch_same_or_higher: cond = !st[0];
				bsme_pkg::op_branch_minus: cond = st[2];
				bsme_pkg::op_branch_plus: cond = !st[2];
				bsme_pkg::op_branch_ge_signed: cond = !(st[2] ^ st[3]);
				bsme_pkg::op_branch_lt_signed: cond = st[2] ^ st[3];
				bsme_pkg::op_branch_half_carry_set: cond = st[5];
				bsme_pkg::op_branch_half_carry_clear: cond = !st[5];
				bsme_pkg::op_branch_tbit_set: cond = st[6];
				default: cond = !st[6];
			endcase
			// signed offset on the incremented pc
			if (cond) begin
				exp_pc = pcv + {{9{x.offset[6]}}, x.offset} + 16'h0001;
				exp_cyc = 2;
			end
		end
	endfunction : model

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Reset values, last address unmapped
		for (int i = 0; i < 6; i++) begin
			wb(1'b0, 5'(4 * i), 32'h0000_0000);
			check(rd_q, (i == 0) ? 32'h0000_0001 : 32'h0000_0000);
		end
		// Multiplies withdrawn: refused and flagged
		wb(1'b1, bsme_pkg::ADR_CTRL, 32'h0000_0000);
		c = '0;
		c.op = bsme_pkg::op_mult_signed_by_unsigned;
		c.rd_val = 8'hff;
		c.rr_val = 8'hff;
		exp_status_register = bsme_pkg::STATUS_REGISTER_RST;
		exp_cyc = 1;
		issue(c);
		wb(1'b0, bsme_pkg::ADR_EVENT, 32'h0000_0000);
		check(rd_q, 32'h0000_0001);
		wb(1'b1, bsme_pkg::ADR_EVENT, 32'h0000_0001);
		wb(1'b0, bsme_pkg::ADR_EVENT, 32'h0000_0000);
		check(rd_q, 32'h0000_0000);
		wb(1'b1, bsme_pkg::ADR_CTRL, 32'h0000_0001);
		// Clock enable low: a pending taken branch must stay frozen
		wb(1'b1, bsme_pkg::ADR_PC, 32'h0000_0100);
		c = '0;
		c.op = bsme_pkg::op_branch_tbit_clear;
		ce_i <= 1'b0;
		cmd_valid_i <= 1'b1;
		cmd_i <= c;
		repeat (3) @(posedge clk_i);
		check(32'(pc_o), 32'h0000_0100);
		check(32'(busy_o), 32'h0000_0000);
		check(32'(done_o), 32'h0000_0000);
		cmd_valid_i <= 1'b0;
		ce_i <= 1'b1;
		@(posedge clk_i);
		// Random instructions with equal operands, the most negative offset and pc wrap mixed in
		for (int i = 0; i < 400; i++) begin
			c = 40'({$random(seed), $random(seed)});
			c.op = bsme_pkg::bsme_op_t'(5'(1 + $unsigned($random(seed)) % 26));
			if (i % 5 == 0) c.rr_val = c.rd_val;
			if (i % 7 == 0) c.offset = 7'h40;
			if (i % 11 == 0) c.rd_val = 8'h80;
			s = 8'($random(seed));
			p = (i % 13 == 0) ? 16'hffff : 16'($random(seed));
			wb(1'b1, bsme_pkg::ADR_STATUS, {24'h00_0000, s});
			wb(1'b1, bsme_pkg::ADR_PC, {16'h0000, p});
			model(c, s, p);
			issue(c);
			check(32'(pc_o), 32'(exp_pc));
			wb(1'b0, bsme_pkg::ADR_PRODUCT, 32'h0000_0000);
			check(rd_q, 32'(exp_prod));
		end
		// Product pair is read-only from the bus
		wb(1'b1, bsme_pkg::ADR_PRODUCT, 32'h0000_a5a5);
		wb(1'b0, bsme_pkg::ADR_PRODUCT, 32'h0000_0000);
		check(rd_q, 32'(exp_prod));
		// Mid-run reset returns pc and product pair to their reset values
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check(32'(pc_o), 32'h0000_0000);
		check(32'(product_o), 32'(bsme_pkg::PRODUCT_RST));
		wrap_up();
	end
endmodule : branch_skip_multiply_exec_test
`default_nettype wire
